// File: core/agcnco_ctrl.sv
// AGC loop and timing oscillator control words with a light loop model.
// Assumes all ports on ref_clk except filter_sync_input, which is a pin.
//
// Operation
// - AGC sync bit: sync loads upper limit into accumulator
// - Gain error is threshold minus magnitude
// - Threshold is 13 bits, signed fixed point
// - Select high uses loop gain set one
// - Select low uses loop gain set zero
// - Step is error times mantissa times exponent shift
// - Mantissa is value over sixteen
// - Upper limit: twelve bit code in bits 27:16
// - Lower limit uses same layout
// - Limit code maps to top twelve accumulator bits
// - Sample strobe write captures loop output
// - Timing sync enabled loads frequency and phase
// - Sync with load bit zeroes accumulator feedback
// - Offset width code selects 8 to 32 bits
// - Offset enable gates offset into adder
// - Clear bit holds accumulator feedback zero
// - Load bit: frequency update zeroes feedback
// - All words run on back-end clock
// - Frequency strobe copies holding to active
`timescale 1ns/10ps
module agcnco_ctrl
#(
  parameter int MAG_W = 16
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire agcnco_pkg::agcnco_bus_s bus,
  output logic [31:0] rdata,
  input wire logic filter_sync_input,
  input wire logic agc_loop_gain_select,
  input wire logic sample_valid,
  input wire logic [MAG_W-1:0] magnitude,
  input wire logic [31:0] offset_freq,
  output logic [31:0] agc_gain,
  output logic [31:0] tnco_freq,
  output logic [7:0] tnco_phase,
  output logic [31:0] tnco_offset,
  output logic [31:0] tnco_accum,
  output logic tnco_fb_zero
);
  logic [31:0] loop_cfg_r;
  logic [31:0] limits_r;
  logic [31:0] tcfg_r;
  logic [31:0] freq_hold_r;
  logic [7:0] phase_hold_r;
  logic [31:0] freq_r;
  logic [7:0] phase_r;
  logic [31:0] gacc_r;
  logic [31:0] gacc_nxt;
  logic [31:0] gsample_r;
  logic [31:0] accum_r;
  logic zero_pulse_r;
  logic [2:0] sync_sh_r;
  logic sync_lvl_r;
  logic sync_pulse;
  logic wr_freq_stb;
  logic wr_sample;
  logic [31:0] rdata_r;

  // Expand a limit code to accumulator scale
  function automatic logic [31:0] lim_to_acc(input logic [11:0] code);
    lim_to_acc = {code, 20'h00000};
  endfunction : lim_to_acc

  // Pin sync filter: change counts when stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_sh_r <= 3'h0;
      sync_lvl_r <= 1'b0;
    end
    else
    begin
      sync_sh_r <= {sync_sh_r[1:0], filter_sync_input};
      if (sync_sh_r[1] == sync_sh_r[2])
        sync_lvl_r <= sync_sh_r[2];
    end
  end
  assign sync_pulse = (sync_sh_r[1] == sync_sh_r[2]) && sync_sh_r[2] && !sync_lvl_r;

  assign wr_freq_stb = bus.wr && (bus.addr == agcnco_pkg::OFS_FREQ_STB);
  assign wr_sample = bus.wr && (bus.addr == agcnco_pkg::OFS_SAMPLE_STB);

  // Configuration words, back-end clock only
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      loop_cfg_r <= agcnco_pkg::RESET_ZERO;
      limits_r <= agcnco_pkg::RESET_ZERO;
      tcfg_r <= agcnco_pkg::RESET_ZERO;
      freq_hold_r <= agcnco_pkg::RESET_ZERO;
      phase_hold_r <= 8'h00;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        agcnco_pkg::OFS_LOOP_CFG: loop_cfg_r <= bus.wdata & agcnco_pkg::LC_MASK;
        agcnco_pkg::OFS_LIMITS: limits_r <= bus.wdata & agcnco_pkg::LIM_MASK;
        agcnco_pkg::OFS_TNCO_CFG: tcfg_r <= bus.wdata & agcnco_pkg::TC_MASK;
        agcnco_pkg::OFS_TNCO_FREQ: freq_hold_r <= bus.wdata;
        agcnco_pkg::OFS_TNCO_PHASE: phase_hold_r <= bus.wdata[7:0];
        default: ;
      endcase
    end
  end

  // AGC loop step
  logic signed [agcnco_pkg::LC_THR_W:0] thr_s;
  logic signed [agcnco_pkg::LC_THR_W+1:0] err_s;
  logic [3:0] mant;
  logic [3:0] expo;
  logic signed [47:0] step_s;
  logic signed [47:0] sum_s;
  logic [31:0] up_acc;
  logic [31:0] lo_acc;
  always_comb
  begin
    thr_s = {loop_cfg_r[agcnco_pkg::LC_THR_LSB+agcnco_pkg::LC_THR_W-1],
             loop_cfg_r[agcnco_pkg::LC_THR_LSB +: agcnco_pkg::LC_THR_W]};
    err_s = (agcnco_pkg::LC_THR_W+2)'(thr_s)
          - (agcnco_pkg::LC_THR_W+2)'({1'b0, magnitude[MAG_W-1 -: agcnco_pkg::LC_THR_W]});
    if (agc_loop_gain_select)
    begin
      mant = loop_cfg_r[agcnco_pkg::LC_M1_LSB +: 4];
      expo = loop_cfg_r[agcnco_pkg::LC_E1_LSB +: 4];
    end
    else
    begin
      mant = loop_cfg_r[agcnco_pkg::LC_M0_LSB +: 4];
      expo = loop_cfg_r[agcnco_pkg::LC_E0_LSB +: 4];
    end
    // Mantissa over sixteen, shifted by 15 minus exponent
    step_s = (48'(err_s) * 48'($signed({1'b0, mant}))) <<< expo;
    step_s = step_s >>> agcnco_pkg::LG_EXP_BASE;
    up_acc = lim_to_acc(limits_r[agcnco_pkg::LIM_UP_LSB +: agcnco_pkg::LIM_W]);
    lo_acc = lim_to_acc(limits_r[agcnco_pkg::LIM_LO_LSB +: agcnco_pkg::LIM_W]);
    sum_s = $signed({16'h0000, gacc_r}) + (step_s <<< agcnco_pkg::GACC_FRAC);
    if (sum_s > $signed({16'h0000, up_acc}))
      gacc_nxt = up_acc;
    else if (sum_s < $signed({16'h0000, lo_acc}))
      gacc_nxt = lo_acc;
    else
      gacc_nxt = sum_s[31:0];
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      gacc_r <= agcnco_pkg::RESET_ZERO;
    else if (sync_pulse && loop_cfg_r[agcnco_pkg::LC_SYNC_BIT])
      gacc_r <= up_acc;
    else if (sample_valid)
      gacc_r <= gacc_nxt;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      gsample_r <= agcnco_pkg::RESET_ZERO;
    else if (wr_sample)
      gsample_r <= gacc_r;
  end

  // Timing oscillator active words
  logic tsync;
  assign tsync = sync_pulse && tcfg_r[agcnco_pkg::TC_SYNC_BIT];
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      freq_r <= agcnco_pkg::RESET_ZERO;
      phase_r <= 8'h00;
    end
    else
    begin
      if (tsync || wr_freq_stb)
        freq_r <= freq_hold_r;
      if (tsync || (bus.wr && bus.addr == agcnco_pkg::OFS_PHASE_STB) ||
          (wr_freq_stb && tcfg_r[agcnco_pkg::TC_LOAD_BIT]))
        phase_r <= phase_hold_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      zero_pulse_r <= 1'b0;
    else
      zero_pulse_r <= tcfg_r[agcnco_pkg::TC_LOAD_BIT] && (tsync || wr_freq_stb);
  end

  logic [31:0] ofs_masked;
  always_comb
  begin
    case (tcfg_r[agcnco_pkg::TC_OW_LSB +: 2])
      2'h0: ofs_masked = {offset_freq[31:24], 24'h000000};
      2'h1: ofs_masked = {offset_freq[31:16], 16'h0000};
      2'h2: ofs_masked = {offset_freq[31:8], 8'h00};
      default: ofs_masked = offset_freq;
    endcase
    if (!tcfg_r[agcnco_pkg::TC_OFS_EN_BIT])
      ofs_masked = agcnco_pkg::RESET_ZERO;
  end

  logic fb_zero;
  assign fb_zero = tcfg_r[agcnco_pkg::TC_CLR_BIT] || zero_pulse_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      accum_r <= agcnco_pkg::RESET_ZERO;
    else
      accum_r <= (fb_zero ? agcnco_pkg::RESET_ZERO : accum_r) + freq_r + ofs_masked;
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= agcnco_pkg::RESET_ZERO;
    else if (bus.rd)
    begin
      case (bus.addr)
        agcnco_pkg::OFS_LOOP_CFG: rdata_r <= loop_cfg_r;
        agcnco_pkg::OFS_LIMITS: rdata_r <= limits_r;
        agcnco_pkg::OFS_TNCO_CFG: rdata_r <= tcfg_r;
        agcnco_pkg::OFS_TNCO_FREQ: rdata_r <= freq_hold_r;
        agcnco_pkg::OFS_TNCO_PHASE: rdata_r <= {24'h000000, phase_hold_r};
        agcnco_pkg::OFS_GAIN_READ: rdata_r <= gsample_r;
        default: rdata_r <= agcnco_pkg::RESET_ZERO;
      endcase
    end
    else
      rdata_r <= agcnco_pkg::RESET_ZERO;
  end

  assign rdata = rdata_r;
  assign agc_gain = gacc_r;
  assign tnco_freq = freq_r;
  assign tnco_phase = phase_r;
  assign tnco_offset = ofs_masked;
  assign tnco_accum = accum_r;
  assign tnco_fb_zero = fb_zero;

  a_agc_sync_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sync_pulse && loop_cfg_r[agcnco_pkg::LC_SYNC_BIT] |=> gacc_r == $past(up_acc))
    else $error("AGC sync load missed");
  a_sample_capture: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_sample |=> gsample_r == $past(gacc_r))
    else $error("Gain sample not captured");
  a_gain_upper_clamp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && lo_acc <= up_acc |=> gacc_r <= $past(up_acc))
    else $error("Gain above upper limit");
  a_freq_strobe_copy: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_freq_stb |=> freq_r == $past(freq_hold_r))
    else $error("Frequency strobe lost");
  a_tsync_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sync_pulse && !tcfg_r[agcnco_pkg::TC_SYNC_BIT] && !wr_freq_stb |=> $stable(freq_r))
    else $error("Sync moved frequency while disabled");
  a_load_zero_fb: assert property (@(posedge ref_clk) disable iff (!rst_b)
    wr_freq_stb && tcfg_r[agcnco_pkg::TC_LOAD_BIT] |=> tnco_fb_zero ##1 accum_r == $past(freq_r) + $past(ofs_masked))
    else $error("Load on update did not zero feedback");
  a_clear_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tcfg_r[agcnco_pkg::TC_CLR_BIT] |=> accum_r == $past(freq_r) + $past(ofs_masked))
    else $error("Clear did not zero feedback");
  a_offset_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !tcfg_r[agcnco_pkg::TC_OFS_EN_BIT] |-> tnco_offset == 32'h00000000)
    else $error("Offset leaked while disabled");
  a_offset_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
    tcfg_r[agcnco_pkg::TC_OFS_EN_BIT] && tcfg_r[4:3] == 2'h0 |-> tnco_offset[23:0] == 24'h000000)
    else $error("Offset width wrong");
  c_agc_sync: cover property (@(posedge ref_clk) sync_pulse && loop_cfg_r[agcnco_pkg::LC_SYNC_BIT]);
  c_sample_read: cover property (@(posedge ref_clk) wr_sample ##1 bus.rd && bus.addr == agcnco_pkg::OFS_GAIN_READ);
  c_tsync_load: cover property (@(posedge ref_clk) tsync && tcfg_r[agcnco_pkg::TC_LOAD_BIT]);
  c_gain_floor: cover property (@(posedge ref_clk) sample_valid ##1 gacc_r == lo_acc);
  c_freq_load: cover property (@(posedge ref_clk) wr_freq_stb && tcfg_r[agcnco_pkg::TC_LOAD_BIT]);

  // AGC loop direction and clamping
  a_gain_lower_clamp: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && lo_acc <= up_acc |=> gacc_r >= $past(lo_acc))
    else $error("Gain below lower limit");

  a_err_negative: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && err_s < 0 |=> gacc_r <= $past(gacc_r) || gacc_r == $past(lo_acc))
    else $error("Gain rose on negative error");

  a_err_positive: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && err_s > 0 |=> gacc_r >= $past(gacc_r) || gacc_r == $past(up_acc))
    else $error("Gain fell on positive error");

  a_set_one_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && agc_loop_gain_select && loop_cfg_r[agcnco_pkg::LC_M1_LSB +: 4] == 4'h0 &&
    gacc_r <= up_acc && gacc_r >= lo_acc |=> $stable(gacc_r))
    else $error("Set one zero mantissa moved gain");

  a_set_zero_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sample_valid && !sync_pulse && !agc_loop_gain_select && loop_cfg_r[agcnco_pkg::LC_M0_LSB +: 4] == 4'h0 &&
    gacc_r <= up_acc && gacc_r >= lo_acc |=> $stable(gacc_r))
    else $error("Set zero zero mantissa moved gain");

  a_gain_idle: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !sample_valid && !sync_pulse |=> $stable(gacc_r))
    else $error("Gain moved without sample");

  a_unsync_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sync_pulse && !loop_cfg_r[agcnco_pkg::LC_SYNC_BIT] && !sample_valid |=> $stable(gacc_r))
    else $error("Sync loaded gain while disabled");

  a_sync_one_shot: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    sync_pulse |=> !sync_pulse)
    else $error("Sync pulse longer than one cycle");

  // Sampled gain and read port
  a_sample_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !wr_sample |=> $stable(gsample_r))
    else $error("Sampled gain changed without strobe");

  a_gain_read: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    bus.rd && bus.addr == agcnco_pkg::OFS_GAIN_READ |=> rdata == $past(gsample_r))
    else $error("Sampled gain read wrong");

  // Reserved bits of stored words
  a_limits_reserved: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (limits_r & ~agcnco_pkg::LIM_MASK) == 32'h00000000)
    else $error("Limit reserved bits set");

  a_loop_reserved: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (loop_cfg_r & ~agcnco_pkg::LC_MASK) == 32'h00000000)
    else $error("Loop config reserved bits set");

  // Timing oscillator loads and accumulator
  a_tsync_freq: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    tsync |=> freq_r == $past(freq_hold_r))
    else $error("Timing sync missed frequency");

  a_tsync_phase: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    tsync |=> phase_r == $past(phase_hold_r))
    else $error("Timing sync missed phase");

  a_sync_zero_fb: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    tsync && tcfg_r[agcnco_pkg::TC_LOAD_BIT] |=> tnco_fb_zero)
    else $error("Sync with load did not zero feedback");

  a_load_phase: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    wr_freq_stb && tcfg_r[agcnco_pkg::TC_LOAD_BIT] |=> phase_r == $past(phase_hold_r))
    else $error("Load on update missed phase");

  a_accum_run: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !fb_zero |=> accum_r == $past(accum_r) + $past(freq_r) + $past(ofs_masked))
    else $error("Accumulator did not accumulate");

  a_offset_full: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    tcfg_r[agcnco_pkg::TC_OFS_EN_BIT] && tcfg_r[4:3] == 2'h3 |-> tnco_offset == offset_freq)
    else $error("Full offset width wrong");
endmodule : agcnco_ctrl

// File: core/agcnco_pkg.sv
// Package for the AGC and timing oscillator control word block.
// Assumes a single back-end clock domain and a plain register port.
package agcnco_pkg;
  // Register offsets (byte addresses, chosen)
  localparam logic [7:0] OFS_LOOP_CFG = 8'h00;
  localparam logic [7:0] OFS_LIMITS = 8'h04;
  localparam logic [7:0] OFS_SAMPLE_STB = 8'h08;
  localparam logic [7:0] OFS_TNCO_CFG = 8'h0C;
  localparam logic [7:0] OFS_TNCO_FREQ = 8'h10;
  localparam logic [7:0] OFS_TNCO_PHASE = 8'h14;
  localparam logic [7:0] OFS_FREQ_STB = 8'h18;
  localparam logic [7:0] OFS_PHASE_STB = 8'h1C;
  localparam logic [7:0] OFS_GAIN_READ = 8'h20;
  // Loop config fields
  localparam int LC_SYNC_BIT = 29;
  localparam int LC_THR_LSB = 16;
  localparam int LC_THR_W = 13;
  localparam int LC_M1_LSB = 12;
  localparam int LC_E1_LSB = 8;
  localparam int LC_M0_LSB = 4;
  localparam int LC_E0_LSB = 0;
  localparam logic [31:0] LC_MASK = 32'h3FFFFFFF;
  localparam int LG_EXP_BASE = 15;
  // Limits fields
  localparam int LIM_UP_LSB = 16;
  localparam int LIM_LO_LSB = 0;
  localparam int LIM_W = 12;
  localparam logic [31:0] LIM_MASK = 32'h0FFF0FFF;
  // Timing oscillator config fields
  localparam int TC_SYNC_BIT = 5;
  localparam int TC_OW_LSB = 3;
  localparam int TC_OFS_EN_BIT = 2;
  localparam int TC_CLR_BIT = 1;
  localparam int TC_LOAD_BIT = 0;
  localparam logic [31:0] TC_MASK = 32'h0000003F;
  localparam logic [31:0] PH_MASK = 32'h000000FF;
  // Gain accumulator: 12 bit code in top of a 32 bit word
  localparam int GACC_W = 32;
  localparam int GACC_FRAC = 20;
  localparam logic [31:0] RESET_ZERO = 32'h00000000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } agcnco_bus_s;
endpackage : agcnco_pkg

// File: tb/agc_timing_nco_control_words_tb_top.sv
// Self-checking bench for the control word block.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
module agc_timing_nco_control_words_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  agcnco_pkg::agcnco_bus_s bus;
  logic [31:0] rdata, agc_gain, tnco_freq, tnco_offset, tnco_accum, rv;
  logic [7:0] tnco_phase;
  logic tnco_fb_zero, seen;
  logic sync_in = 1'b0;
  logic gain_sel = 1'b0;
  logic s_valid = 1'b0;
  logic [15:0] mag = 16'h0000;
  logic [31:0] ofs = 32'h12345678;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} agcnco_row_s;
  agcnco_row_s rows [5];
  always #10 ref_clk = ~ref_clk;
  agcnco_host agcnco_host_inst (.ref_clk(ref_clk), .rdata(rdata), .bus(bus));
  agcnco_ctrl agcnco_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .filter_sync_input(sync_in), .agc_loop_gain_select(gain_sel), .sample_valid(s_valid),
    .magnitude(mag), .offset_freq(ofs), .agc_gain(agc_gain), .tnco_freq(tnco_freq),
    .tnco_phase(tnco_phase), .tnco_offset(tnco_offset), .tnco_accum(tnco_accum), .tnco_fb_zero(tnco_fb_zero));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Holds sync high long enough for the pin filter, notes feedback zeroing
  task automatic pulse(output logic s);
    s = 1'b0;
    @(posedge ref_clk);
    sync_in <= 1'b1;
    repeat (10)
    begin
      @(negedge ref_clk);
      s = s | tnco_fb_zero;
    end
    @(posedge ref_clk);
    sync_in <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    agcnco_host_inst.wr(a, d);
  endtask : wr
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    rows[0] = '{agcnco_pkg::OFS_LOOP_CFG, 32'hFFFFFFFF, agcnco_pkg::LC_MASK};
    rows[1] = '{agcnco_pkg::OFS_LIMITS, 32'hFFFFFFFF, agcnco_pkg::LIM_MASK};
    rows[2] = '{agcnco_pkg::OFS_TNCO_CFG, 32'hFFFFFFFF, agcnco_pkg::TC_MASK};
    rows[3] = '{agcnco_pkg::OFS_TNCO_PHASE, 32'hFFFFFFFF, agcnco_pkg::PH_MASK};
    rows[4] = '{8'h40, 32'hFFFFFFFF, 32'h00000000};
    repeat (16) @(posedge ref_clk);
    chk(agc_gain | tnco_freq | tnco_offset, 32'h0);
    rst_b <= 1'b1;
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      agcnco_host_inst.rd(rows[i].a, rv);
      chk(rv, rows[i].e);
    end
    $display("test registers done");
    for (int w = 0; w < 4; w++)
    begin
      wr(agcnco_pkg::OFS_TNCO_CFG, 32'(w * 8 + 4));
      @(negedge ref_clk);
      chk(tnco_offset, ofs & ~(32'hFFFFFFFF >> (8 * (w + 1))));
    end
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000018);
    @(negedge ref_clk);
    chk(tnco_offset, 32'h0);
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000002);
    @(negedge ref_clk);
    chk({31'h0, tnco_fb_zero}, 32'h1);
    $display("test offset done");
    wr(agcnco_pkg::OFS_TNCO_FREQ, 32'h01000000);
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000001);
    wr(agcnco_pkg::OFS_FREQ_STB, 32'h0);
    @(negedge ref_clk);
    chk({31'h0, tnco_fb_zero}, 32'h1);
    chk(tnco_freq, 32'h01000000);
    @(negedge ref_clk);
    chk(tnco_accum, 32'h01000000);
    wr(agcnco_pkg::OFS_TNCO_PHASE, 32'h0000005A);
    wr(agcnco_pkg::OFS_PHASE_STB, 32'h0);
    @(negedge ref_clk);
    chk({24'h0, tnco_phase}, 32'h5A);
    $display("test strobes done");
    wr(agcnco_pkg::OFS_TNCO_FREQ, 32'h00ABCDEF);
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000000);
    pulse(seen);
    chk(tnco_freq, 32'h01000000);
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000020);
    pulse(seen);
    chk(tnco_freq, 32'h00ABCDEF);
    chk({31'h0, seen}, 32'h0);
    wr(agcnco_pkg::OFS_TNCO_CFG, 32'h00000021);
    pulse(seen);
    chk({31'h0, seen}, 32'h1);
    $display("test sync done");
    wr(agcnco_pkg::OFS_LIMITS, 32'h0ABC0123);
    wr(agcnco_pkg::OFS_LOOP_CFG, 32'h2000FF00);
    mag <= 16'hFFFF;
    pulse(seen);
    chk(agc_gain, 32'hABC00000);
    s_valid <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(agc_gain, 32'hABC00000);
    wr(agcnco_pkg::OFS_SAMPLE_STB, 32'h0);
    gain_sel <= 1'b1;
    agcnco_host_inst.rd(agcnco_pkg::OFS_GAIN_READ, rv);
    chk(rv, 32'hABC00000);
    repeat (20) @(posedge ref_clk);
    chk({31'h0, agc_gain[31:20] < 12'hABC}, 32'h1);
    repeat (800) @(posedge ref_clk);
    chk({31'h0, agc_gain[31:20] >= 12'h123}, 32'h1);
    $display("test agc done");
    final_report();
  end
endmodule : agc_timing_nco_control_words_tb_top

// File: tb/agcnco_host.sv
// Bus master model standing in for the external processor.
// Assumes the block samples strobes on the rising ref_clk edge.
`timescale 1ns/10ps
module agcnco_host
(
  input wire logic ref_clk,
  input wire logic [31:0] rdata,
  output agcnco_pkg::agcnco_bus_s bus
);
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask : rd
endmodule : agcnco_host
